// file: rtl/gsm_pkg.sv
// shared constants of the gate switching monitor
package gsm_pkg;

  // ==========================================================
  // timer geometry
  localparam int GSM_CNT_W = 8;
  localparam logic [7:0] GSM_CNT_MAX = 8'hff;
  localparam logic [7:0] GSM_CNT_RST = 8'h00;

  // ==========================================================
  // register byte addresses
  localparam int GSM_ADDR_W = 8;
  localparam logic [7:0] GSM_ADDR_CTRL = 8'h00;
  localparam logic [7:0] GSM_ADDR_STATUS = 8'h04;
  localparam logic [7:0] GSM_ADDR_TIMES = 8'h08;
  localparam logic [7:0] GSM_ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] GSM_ADDR_IRQ_MASK = 8'h10;

  // ==========================================================
  // control register fields
  localparam int GSM_CTRL_ARM = 0;
  localparam int GSM_CTRL_FCLR = 1;
  localparam int GSM_CTRL_VERIF = 2;
  localparam int GSM_CTRL_WEAK = 3;
  localparam int GSM_CTRL_LVL_LO = 4;
  localparam int GSM_LVL_W = 4;
  localparam logic [3:0] GSM_LVL_RST = 4'h0;
  localparam logic [3:0] GSM_LVL_FULL = 4'hf;

  // ==========================================================
  // status and interrupt fields
  localparam int GSM_ST_FAULT = 0;
  localparam int GSM_ST_ON_ARMED = 1;
  localparam int GSM_ST_OFF_ARMED = 2;
  localparam int GSM_ST_ON_RUN = 3;
  localparam int GSM_ST_OFF_RUN = 4;
  localparam int GSM_IRQ_W = 3;
  localparam int GSM_IRQ_FAULT = 0;
  localparam int GSM_IRQ_ON_CAP = 1;
  localparam int GSM_IRQ_OFF_CAP = 2;
  localparam logic [2:0] GSM_IRQ_RST = 3'h0;

endpackage : gsm_pkg

// file: rtl/gsm_chan_if.sv
// link between the monitor core and one gate timer channel
`timescale 1ns/1ps
`default_nettype none
interface gsm_chan_if;
  logic start;
  logic reached;
  logic to_en;
  logic armed;
  logic fault;
  logic cap_done;
  logic [7:0] cap_val;
  logic running;

  modport ctrl (
    output start,
    output reached,
    output to_en,
    output armed,
    input fault,
    input cap_done,
    input cap_val,
    input running
  );

  modport chan (
    input start,
    input reached,
    input to_en,
    input armed,
    output fault,
    output cap_done,
    output cap_val,
    output running
  );
endinterface : gsm_chan_if
`default_nettype wire

// file: rtl/gsm_timer_chan.sv
// one gate transition timer: timeout check and one-shot capture
`timescale 1ns/1ps
`default_nettype none
module gsm_timer_chan
  import gsm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // core side
  gsm_chan_if.chan ch
);

  logic [7:0] cnt_q;
  logic running_q;
  logic cap_active_q;
  logic fault_q;
  logic cap_done_q;
  logic [7:0] cap_val_q;
  logic at_max;
  logic ending;

  assign at_max = (cnt_q == GSM_CNT_MAX);
  // one more tick at the top would wrap: treat it as overflow
  assign ending = running_q && !ch.start && (ch.reached || at_max);

  // ==========================================================
  // counter
  // clear and count
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= GSM_CNT_RST;
      running_q <= 1'b0;
    end else if (ch.start) begin
      cnt_q <= GSM_CNT_RST;
      running_q <= 1'b1;
    end else if (running_q) begin
      if (ch.reached || at_max) begin
        running_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cap_active_q <= 1'b0;
    end else if (ch.start) begin
      cap_active_q <= ch.armed;
    end else if (ending) begin
      cap_active_q <= 1'b0;
    end
  end

  // ==========================================================
  // results
  // overflow raises the timeout event
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= running_q && !ch.start && !ch.reached && at_max && ch.to_en;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cap_done_q <= 1'b0;
      cap_val_q <= GSM_CNT_RST;
    end else begin
      cap_done_q <= ending && cap_active_q;
      if (ending && cap_active_q) begin
        cap_val_q <= ch.reached ? cnt_q : GSM_CNT_MAX;
      end
    end
  end

  assign ch.fault = fault_q;
  assign ch.cap_done = cap_done_q;
  assign ch.cap_val = cap_val_q;
  assign ch.running = running_q;

  // ==========================================================
  // checks
  chk_start_clears: assert property (@(posedge clk_sys) disable iff (rst)
    ch.start |=> (cnt_q == 8'h00) && running_q) else $error("start did not clear the timer");
  chk_stop_reached: assert property (@(posedge clk_sys) disable iff (rst)
    running_q && ch.reached && !ch.start |=> !running_q) else $error("timer ran past threshold");
  chk_fault_overflow: assert property (@(posedge clk_sys) disable iff (rst)
    fault_q |-> $past(cnt_q) == 8'hff && $past(running_q)) else $error("fault without overflow");
  chk_cap_saturate: assert property (@(posedge clk_sys) disable iff (rst)
    cap_done_q && !$past(ch.reached) |-> cap_val_q == 8'hff) else $error("capture not saturated");
  chk_cap_once: assert property (@(posedge clk_sys) disable iff (rst)
    cap_done_q |-> !cap_active_q) else $error("capture still active after done");

endmodule : gsm_timer_chan
`default_nettype wire

// file: rtl/gsm_monitor.sv
// gate switching monitor: timeouts, timing capture, apb registers
//
// Behaviour
// - turn-on start clears an 8-bit timer; stops at upper threshold; overflow sets fault.
// - hard turn-off transition clears timer; stops at lower threshold; overflow sets fault.
// - verification or weak-on mode suppresses turn-on timeout only; turn-off stays.
// - arm command sets both turn-on and turn-off capture armed flags.
// - once armed, exactly one capture per direction until re-armed.
// - armed turn-on clears its time, counts, stores count at upper threshold, disarms.
// - armed turn-off clears its time, counts, stores count at lower threshold, disarms.
// - capture overflow stores saturated ff instead of a wrapped count.
// - weak-on mode drives turn-on at the reduced level from a config field.
`timescale 1ns/1ps
`default_nettype none
module gsm_monitor
  import gsm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [GSM_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // switching sequence events
  input wire logic turnon_start,
  input wire logic turnoff_hard,
  // gate comparators, asynchronous
  input wire logic gate_high_cmp,
  input wire logic gate_low_cmp,
  // outputs
  output logic gate_fault_flag,
  output logic [GSM_LVL_W-1:0] turnon_level_sel,
  output logic irq
);

  // ==========================================================
  // declarations
  logic high_s1_q;
  logic high_s2_q;
  logic low_s1_q;
  logic low_s2_q;
  logic verif_mode_q;
  logic weak_on_mode_q;
  logic [GSM_LVL_W-1:0] weak_lvl_q;
  logic [GSM_LVL_W-1:0] level_q;
  logic fault_q;
  logic on_armed_q;
  logic off_armed_q;
  logic [7:0] on_time_q;
  logic [7:0] off_time_q;
  logic [GSM_IRQ_W-1:0] irq_stat_q;
  logic [GSM_IRQ_W-1:0] irq_mask_q;
  logic [GSM_IRQ_W-1:0] irq_set;
  logic [31:0] rdata_q;
  logic slverr_q;
  logic setup_phase;
  logic wr_access;
  logic rd_access;
  logic arm_cmd;
  logic fault_clr;
  logic [31:0] rd_mux;

  gsm_chan_if on_if ();
  gsm_chan_if off_if ();

  // ==========================================================
  // helpers
  function automatic logic addr_is(input logic [GSM_ADDR_W-1:0] a, input logic [7:0] reg_addr);
    addr_is = (a == reg_addr);
  endfunction : addr_is

  function automatic logic addr_mapped(input logic [GSM_ADDR_W-1:0] a);
    addr_mapped = addr_is(a, GSM_ADDR_CTRL) || addr_is(a, GSM_ADDR_STATUS) ||
                  addr_is(a, GSM_ADDR_TIMES) || addr_is(a, GSM_ADDR_IRQ_STAT) ||
                  addr_is(a, GSM_ADDR_IRQ_MASK);
  endfunction : addr_mapped

  // ==========================================================
  // comparator synchronisers
  // two flops per comparator, only the second one is used
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      high_s1_q <= 1'b0;
      high_s2_q <= 1'b0;
      low_s1_q <= 1'b0;
      low_s2_q <= 1'b0;
    end else begin
      high_s1_q <= gate_high_cmp;
      high_s2_q <= high_s1_q;
      low_s1_q <= gate_low_cmp;
      low_s2_q <= low_s1_q;
    end
  end

  // ==========================================================
  // timer channels
  // the sync adds two cycles of latency to every measured time
  assign on_if.start = turnon_start;
  assign on_if.reached = high_s2_q;
  // turn-on timeout off in test modes
  assign on_if.to_en = !(verif_mode_q || weak_on_mode_q);
  assign on_if.armed = on_armed_q;

  assign off_if.start = turnoff_hard;
  assign off_if.reached = low_s2_q;
  assign off_if.to_en = 1'b1;
  assign off_if.armed = off_armed_q;

  gsm_timer_chan u_on_chan (
    .clk_sys(clk_sys),
    .rst(rst),
    .ch(on_if.chan)
  );

  gsm_timer_chan u_off_chan (
    .clk_sys(clk_sys),
    .rst(rst),
    .ch(off_if.chan)
  );

  // ==========================================================
  // apb decode
  // zero wait states; read data is sampled in the setup cycle
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pwrite && addr_mapped(paddr);
  assign rd_access = psel && penable && !pwrite;
  assign arm_cmd = wr_access && addr_is(paddr, GSM_ADDR_CTRL) && pwdata[GSM_CTRL_ARM];
  assign fault_clr = wr_access && addr_is(paddr, GSM_ADDR_CTRL) && pwdata[GSM_CTRL_FCLR];
  assign pready = 1'b1;
  assign prdata = rdata_q;
  assign pslverr = slverr_q;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_is(paddr, GSM_ADDR_CTRL)) begin
      rd_mux[GSM_CTRL_VERIF] = verif_mode_q;
      rd_mux[GSM_CTRL_WEAK] = weak_on_mode_q;
      rd_mux[GSM_CTRL_LVL_LO +: GSM_LVL_W] = weak_lvl_q;
    end else if (addr_is(paddr, GSM_ADDR_STATUS)) begin
      rd_mux[GSM_ST_FAULT] = fault_q;
      rd_mux[GSM_ST_ON_ARMED] = on_armed_q;
      rd_mux[GSM_ST_OFF_ARMED] = off_armed_q;
      rd_mux[GSM_ST_ON_RUN] = on_if.running;
      rd_mux[GSM_ST_OFF_RUN] = off_if.running;
    end else if (addr_is(paddr, GSM_ADDR_TIMES)) begin
      rd_mux[15:0] = {off_time_q, on_time_q};
    end else if (addr_is(paddr, GSM_ADDR_IRQ_STAT)) begin
      rd_mux[GSM_IRQ_W-1:0] = irq_stat_q;
    end else if (addr_is(paddr, GSM_ADDR_IRQ_MASK)) begin
      rd_mux[GSM_IRQ_W-1:0] = irq_mask_q;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (setup_phase) begin
      rdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      slverr_q <= !addr_mapped(paddr);
    end
  end

  // ==========================================================
  // control register
  // weak-on selects the reduced turn-on level
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      verif_mode_q <= 1'b0;
      weak_on_mode_q <= 1'b0;
      weak_lvl_q <= GSM_LVL_RST;
      level_q <= GSM_LVL_FULL;
    end else begin
      if (wr_access && addr_is(paddr, GSM_ADDR_CTRL)) begin
        verif_mode_q <= pwdata[GSM_CTRL_VERIF];
        weak_on_mode_q <= pwdata[GSM_CTRL_WEAK];
        weak_lvl_q <= pwdata[GSM_CTRL_LVL_LO +: GSM_LVL_W];
      end
      level_q <= weak_on_mode_q ? weak_lvl_q : GSM_LVL_FULL;
    end
  end

  assign turnon_level_sel = level_q;

  // ==========================================================
  // fault flag
  // either timeout sets the sticky fault; set beats clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= (fault_q && !fault_clr) || on_if.fault || off_if.fault;
    end
  end

  assign gate_fault_flag = fault_q;

  // ==========================================================
  // capture arming
  // arm sets both flags; a new arm beats a finishing capture
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      on_armed_q <= 1'b0;
      off_armed_q <= 1'b0;
    end else begin
      on_armed_q <= (on_armed_q && !on_if.cap_done) || arm_cmd;
      off_armed_q <= (off_armed_q && !off_if.cap_done) || arm_cmd;
    end
  end

  // ==========================================================
  // measured times
  // turn-on time cleared at an armed start, loaded at threshold
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      on_time_q <= GSM_CNT_RST;
    end else if (on_if.cap_done) begin
      on_time_q <= on_if.cap_val;
    end else if (turnon_start && on_armed_q) begin
      on_time_q <= GSM_CNT_RST;
    end
  end

  // turn-off time cleared at an armed hard transition, loaded at threshold
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      off_time_q <= GSM_CNT_RST;
    end else if (off_if.cap_done) begin
      off_time_q <= off_if.cap_val;
    end else if (turnoff_hard && off_armed_q) begin
      off_time_q <= GSM_CNT_RST;
    end
  end

  // ==========================================================
  // interrupts
  // only bits that were returned by the read are cleared, so an
  // event landing between setup and access is kept
  assign irq_set[GSM_IRQ_FAULT] = on_if.fault || off_if.fault;
  assign irq_set[GSM_IRQ_ON_CAP] = on_if.cap_done;
  assign irq_set[GSM_IRQ_OFF_CAP] = off_if.cap_done;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_stat_q <= GSM_IRQ_RST;
    end else if (rd_access && addr_is(paddr, GSM_ADDR_IRQ_STAT)) begin
      irq_stat_q <= (irq_stat_q & ~rdata_q[GSM_IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_mask_q <= GSM_IRQ_RST;
    end else if (wr_access && addr_is(paddr, GSM_ADDR_IRQ_MASK)) begin
      irq_mask_q <= pwdata[GSM_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ==========================================================
  // checks
  chk_arm_sets_both: assert property (@(posedge clk_sys) disable iff (rst)
    arm_cmd |=> on_armed_q && off_armed_q) else $error("arm did not set both flags");
  chk_on_timeout_mode: assert property (@(posedge clk_sys) disable iff (rst)
    on_if.fault |-> !$past(verif_mode_q) && !$past(weak_on_mode_q)) else $error("turn-on timeout in test mode");
  chk_fault_sticky: assert property (@(posedge clk_sys) disable iff (rst)
    fault_q && !fault_clr |=> fault_q) else $error("fault flag dropped");
  chk_on_disarm: assert property (@(posedge clk_sys) disable iff (rst)
    on_if.cap_done && !arm_cmd |=> !on_armed_q && on_time_q == $past(on_if.cap_val)) else $error("turn-on capture");
  chk_off_disarm: assert property (@(posedge clk_sys) disable iff (rst)
    off_if.cap_done && !arm_cmd |=> !off_armed_q && off_time_q == $past(off_if.cap_val)) else $error("turn-off capture");
  chk_high_sync: assert property (@(posedge clk_sys) disable iff (rst)
    gate_high_cmp [*2] |=> high_s2_q) else $error("upper comparator sync latency");
  chk_weak_level: assert property (@(posedge clk_sys) disable iff (rst)
    weak_on_mode_q && $stable(weak_lvl_q) |=> turnon_level_sel == $past(weak_lvl_q)) else $error("weak level");

endmodule : gsm_monitor
`default_nettype wire

// file: tb/gsm_gate_model.sv
// gate model: comparator levels follow switching events after set delays
`timescale 1ns/1ps
`default_nettype none
module gsm_gate_model (
  // clock
  input wire logic clk_sys,
  // switching events
  input wire logic turnon_start,
  input wire logic turnoff_hard,
  // delays in cycles, zero means the gate never gets there
  input wire logic [8:0] on_dly,
  input wire logic [8:0] off_dly,
  // comparators
  output logic gate_high_cmp,
  output logic gate_low_cmp
);
  logic [8:0] on_cnt_q = 9'h000;
  logic [8:0] off_cnt_q = 9'h000;
  // ==========================================================
  // gate starts discharged
  initial begin
    gate_high_cmp = 1'b0;
    gate_low_cmp = 1'b1;
  end
  // the gate leaves the opposite threshold at once, reaches the target late
  always @(posedge clk_sys) begin
    if (turnon_start) begin
      gate_low_cmp <= 1'b0;
      on_cnt_q <= on_dly;
    end else if (on_cnt_q != 9'h000) begin
      on_cnt_q <= on_cnt_q - 9'h001;
      if (on_cnt_q == 9'h001) begin
        gate_high_cmp <= 1'b1;
      end
    end
    if (turnoff_hard) begin
      gate_high_cmp <= 1'b0;
      off_cnt_q <= off_dly;
    end else if (off_cnt_q != 9'h000) begin
      off_cnt_q <= off_cnt_q - 9'h001;
      if (off_cnt_q == 9'h001) begin
        gate_low_cmp <= 1'b1;
      end
    end
  end
endmodule : gsm_gate_model
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench of the gate switching monitor
`timescale 1ns/1ps
`default_nettype none
module testbench
  import gsm_pkg::*;
;
  typedef struct {
    logic [8:0] on_d;
    logic [8:0] off_d;
    logic [7:0] ctrl;
    logic [7:0] on_t;
    logic [7:0] off_t;
    logic flt;
  } gsm_row_t;
  // ==========================================================
  // signals
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic turnon_start, turnoff_hard, gate_high_cmp, gate_low_cmp, gate_fault_flag, irq, erv;
  logic [3:0] turnon_level_sel;
  logic [8:0] on_dly, off_dly;
  int errors = 0;
  int check_count = 0;
  // stored time is delay plus two: the model's comparator edge lands after a clock edge,
  // then passes both sync flops before the timer stops
  gsm_row_t rows [6] = '{
    '{9'd1, 9'd1, 8'h03, 8'h03, 8'h03, 1'b0},
    '{9'd5, 9'd9, 8'h03, 8'h07, 8'h0b, 1'b0},
    '{9'd0, 9'd3, 8'h03, 8'hff, 8'h05, 1'b1},
    '{9'd0, 9'd3, 8'h07, 8'hff, 8'h05, 1'b0},
    '{9'd0, 9'd3, 8'h0b, 8'hff, 8'h05, 1'b0},
    '{9'd2, 9'd0, 8'h0b, 8'h04, 8'hff, 1'b1}};
  // ==========================================================
  // design and gate
  gsm_monitor u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .turnon_start(turnon_start), .turnoff_hard(turnoff_hard), .gate_high_cmp(gate_high_cmp),
    .gate_low_cmp(gate_low_cmp), .gate_fault_flag(gate_fault_flag),
    .turnon_level_sel(turnon_level_sel), .irq(irq));
  gsm_gate_model u_gate (.clk_sys(clk_sys), .turnon_start(turnon_start), .turnoff_hard(turnoff_hard),
    .on_dly(on_dly), .off_dly(off_dly), .gate_high_cmp(gate_high_cmp), .gate_low_cmp(gate_low_cmp));
  // ==========================================================
  // tasks
  task automatic give_verdict();
    if (errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // master waits for pready with no assumed latency
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, exp, rdv);
  endtask : rd_chk
  // one turn-on then one turn-off, each given time to overflow
  task automatic switch_pair(input logic [8:0] on_d, input logic [8:0] off_d);
    on_dly <= on_d;
    off_dly <= off_d;
    @(posedge clk_sys);
    turnon_start <= 1'b1;
    @(posedge clk_sys);
    turnon_start <= 1'b0;
    repeat (300) @(posedge clk_sys);
    turnoff_hard <= 1'b1;
    @(posedge clk_sys);
    turnoff_hard <= 1'b0;
    repeat (300) @(posedge clk_sys);
  endtask : switch_pair
  // ==========================================================
  // clock, watchdog, sequence
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #200us;
    errors++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    turnon_start = 1'b0;
    turnoff_hard = 1'b0;
    on_dly = 9'd1;
    off_dly = 9'd1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    chk("fault_rst", 32'h0, gate_fault_flag);
    chk("level_rst", 32'hf, turnon_level_sel);
    chk("irq_rst", 32'h0, irq);
    rd_chk("status_rst", GSM_ADDR_STATUS, 32'h0);
    rd_chk("times_rst", GSM_ADDR_TIMES, 32'h0);
    rd_chk("mask_rst", GSM_ADDR_IRQ_MASK, 32'h0);
    apb(1'b1, GSM_ADDR_IRQ_MASK, 32'h0000_0007);
    foreach (rows[i]) begin
      apb(1'b1, GSM_ADDR_CTRL, {24'h0, rows[i].ctrl});
      switch_pair(rows[i].on_d, rows[i].off_d);
      rd_chk("times", GSM_ADDR_TIMES, {16'h0, rows[i].off_t, rows[i].on_t});
      rd_chk("status", GSM_ADDR_STATUS, {31'h0, rows[i].flt});
      chk("fault_pin", {31'h0, rows[i].flt}, gate_fault_flag);
      chk("irq_set", 32'h1, irq);
      rd_chk("irq_stat", GSM_ADDR_IRQ_STAT, {29'h0, 2'b11, rows[i].flt});
      // the read clear lands on the access edge: look once it has settled
      @(negedge clk_sys);
      chk("irq_clr", 32'h0, irq);
    end
    // unarmed sequence must leave captured times alone
    switch_pair(9'd1, 9'd1);
    rd_chk("times_hold", GSM_ADDR_TIMES, 32'h0000_ff04);
    rd_chk("irq_none", GSM_ADDR_IRQ_STAT, 32'h0);
    apb(1'b1, GSM_ADDR_CTRL, 32'h0000_0003);
    rd_chk("armed", GSM_ADDR_STATUS, 32'h6);
    // masked captures keep the interrupt line low
    apb(1'b1, GSM_ADDR_IRQ_MASK, 32'h0000_0000);
    switch_pair(9'd1, 9'd1);
    chk("irq_masked", 32'h0, irq);
    rd_chk("irq_pend", GSM_ADDR_IRQ_STAT, 32'h6);
    rd_chk("times_new", GSM_ADDR_TIMES, 32'h0000_0303);
    chk("slverr_ok", 32'h0, erv);
    apb(1'b1, GSM_ADDR_CTRL, 32'h0000_0058);
    repeat (2) @(posedge clk_sys);
    chk("level_weak", 32'h5, turnon_level_sel);
    apb(1'b1, GSM_ADDR_CTRL, 32'h0000_0050);
    repeat (2) @(posedge clk_sys);
    chk("level_full", 32'hf, turnon_level_sel);
    // a turn-on timer that is still counting shows in the status word
    on_dly <= 9'd0;
    turnon_start <= 1'b1;
    @(posedge clk_sys);
    turnon_start <= 1'b0;
    rd_chk("status_run", GSM_ADDR_STATUS, 32'h8);
    rd_chk("unmapped", 8'h14, 32'h0);
    chk("slverr", 32'h1, erv);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
